// File: shared/ewci_pkg.sv
/*
 * Package of the external weld control input block: register map, field
 * positions, reset values, timing counts and the carrier structs.
 * Assumes a 10 MHz system clock and an AHB-Lite bus with 32-bit data.
 */
package ewci_pkg;
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned END_MS        = 40;
    localparam int unsigned END_CYCLES    = (CLK_HZ / 1000) * END_MS;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_INPUTS    = 8'h08;

    // CTRL fields
    localparam int unsigned CTRL_HV       = 0;
    localparam int unsigned CTRL_AIM      = 1;
    localparam int unsigned CTRL_CAVITY   = 2;
    localparam int unsigned CTRL_DLV_LSB  = 4;
    localparam int unsigned CTRL_PRG_LSB  = 8;
    localparam int unsigned CTRL_CLR      = 13;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // STATUS fields
    localparam int unsigned ST_HV         = 0;
    localparam int unsigned ST_READY      = 1;
    localparam int unsigned ST_FAULT_FREE = 2;
    localparam int unsigned ST_END        = 3;
    localparam int unsigned ST_ACCEPT     = 4;
    localparam int unsigned ST_EMIT       = 5;
    localparam int unsigned ST_WELD_HALT  = 6;
    localparam int unsigned ST_BRANCH     = 7;
    localparam int unsigned ST_DLV_LSB    = 8;
    localparam int unsigned ST_PRG_LSB    = 12;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic       high_voltage_switch;
        logic       fault_clear;
        logic       trigger;
        logic       halt;
        logic       aim;
        logic       external_control_select;
        logic       cavity_shutter;
        logic [3:0] delivery_sel;
        logic [4:0] program_sel;
    } ewci_contacts_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ewci_ahb_req_t;
endpackage : ewci_pkg

// File: logic/ewci_top.sv
/*
 * Decoder of the discrete contact inputs of the main control connector,
 * the stop connector and the door interlock, with an AHB-Lite register file.
 * Assumes contacts arrive as closed-high levels and one 10 MHz clock.
 */
// Contract
// - High voltage follows its switch input (code: only while external select is closed, else CTRL bit 0)
// - Fault clear acts only once cause gone
// - Halt input ends repeated output, 1 ms
// - Aiming light only while request held
// - Other inputs act only when selected
// - Four independent delivery unit selects
// - Program number is weighted five-bit sum
// - Stop connector error halts welding
// - Door open closes branch shutter at once
// - Ready when voltage on and charged
// - Pulse-end output 40 ms after flash
// - Fault-free low until fault cleared
// - Input-accepted follows external select
`timescale 1ns/1ps
module ewci_top
    import ewci_pkg::*;
#(
    parameter int unsigned END_LEN = END_CYCLES
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_resetn,
    input  wire ewci_pkg::ewci_ahb_req_t i_ahb,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    output logic [31:0]               o_hrdata,
    input  wire ewci_pkg::ewci_contacts_t i_contacts,
    input  wire logic                 i_stop_error,
    input  wire logic                 i_stop_request,
    input  wire logic                 i_door_open,
    input  wire logic                 i_fault_event,
    input  wire logic                 i_fault_cause,
    input  wire logic                 i_cap_charged,
    input  wire logic                 i_lamp_flashed,
    output logic                      o_high_voltage,
    output logic                      o_ready,
    output logic                      o_fault_free,
    output logic                      o_pulse_end,
    output logic                      o_input_accepted,
    output logic                      o_fire,
    output logic                      o_emitting,
    output logic                      o_aim_light,
    output logic                      o_cavity_open,
    output logic [3:0]                o_delivery_sel,
    output logic [4:0]                o_program,
    output logic                      o_weld_halt,
    output logic                      o_branch_close
);
    import ewci_pkg::*;

    localparam int unsigned SW = $bits(ewci_contacts_t) + 3;

    logic [SW-1:0]  sync1_q;
    logic [SW-1:0]  sync2_q;
    ewci_contacts_t cin;
    logic           stop_err_s;
    logic           stop_req_s;
    logic           door_s;
    logic           trig_prev_q;
    logic           halt_prev_q;
    logic           sel;
    logic [31:0]    ctrl_q;
    logic           clr_pulse;
    logic           fault_q;
    logic [31:0]    end_cnt_q;
    logic           emit_q;
    logic           fire_q;
    logic           hv_q;
    logic           aim_q;
    logic           cav_q;
    logic [3:0]     dlv_q;
    logic [4:0]     prg_q;
    logic           halt_q;
    logic           branch_q;
    logic           ph_wr_q;
    logic [7:0]     ph_addr_q;
    logic           acc;
    logic [31:0]    status;
    logic [31:0]    rdata_q;
    logic           trig_rise;
    logic           halt_rise;

    // Two-stage contact synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {i_stop_error, i_stop_request, i_door_open, i_contacts};
            sync2_q <= sync1_q;
        end
    end

    assign cin        = ewci_contacts_t'(sync2_q[SW-4:0]);
    assign stop_err_s = sync2_q[SW-1];
    assign stop_req_s = sync2_q[SW-2];
    assign door_s     = sync2_q[SW-3];
    assign sel        = cin.external_control_select;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            trig_prev_q <= 1'b0;
            halt_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= cin.trigger;
            halt_prev_q <= cin.halt;
        end
    end

    assign trig_rise = sel && cin.trigger && !trig_prev_q;
    assign halt_rise = sel && cin.halt && !halt_prev_q;

    // Steered outputs: contacts when selected, CTRL register otherwise; weld halt from stop inputs, branch from door
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            hv_q     <= 1'b0;
            aim_q    <= 1'b0;
            cav_q    <= 1'b0;
            dlv_q    <= '0;
            prg_q    <= '0;
            halt_q   <= 1'b0;
            branch_q <= 1'b0;
        end else begin
            hv_q     <= sel ? cin.high_voltage_switch : ctrl_q[CTRL_HV];
            aim_q    <= sel ? cin.aim : ctrl_q[CTRL_AIM];
            cav_q    <= sel ? cin.cavity_shutter : ctrl_q[CTRL_CAVITY];
            dlv_q    <= sel ? cin.delivery_sel : ctrl_q[CTRL_DLV_LSB +: 4];
            prg_q    <= sel ? cin.program_sel : ctrl_q[CTRL_PRG_LSB +: 5];
            halt_q   <= stop_err_s || stop_req_s;
            branch_q <= door_s;
        end
    end

    // Fault latch, set wins over clear
    assign clr_pulse = (sel && cin.fault_clear) || (ph_wr_q && ph_addr_q == OFS_CTRL
                       && i_ahb.hwdata[CTRL_CLR]);
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            fault_q <= 1'b0;
        end else if (i_fault_event) begin
            fault_q <= 1'b1;
        end else if (clr_pulse && !i_fault_cause) begin
            fault_q <= 1'b0;
        end
    end

    // Fire on trigger edge, emission held until halt, stop, fault or high voltage off
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            fire_q <= 1'b0;
            emit_q <= 1'b0;
        end else begin
            fire_q <= trig_rise && cin.halt && o_ready && !fault_q && !halt_q;
            if (halt_rise || halt_q || fault_q || !hv_q) begin
                emit_q <= 1'b0;
            end else if (fire_q) begin
                emit_q <= 1'b1;
            end
        end
    end

    // Pulse-end stretcher
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            end_cnt_q <= '0;
        end else if (i_lamp_flashed) begin
            end_cnt_q <= END_LEN;
        end else if (end_cnt_q != '0) begin
            end_cnt_q <= end_cnt_q - 32'h0000_0001;
        end
    end

    // AHB-Lite slave, zero wait states
    assign acc = i_ahb.hsel && i_ahb.htrans == HTRANS_NONSEQ && i_ahb.hready;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ph_wr_q   <= 1'b0;
            ph_addr_q <= '0;
        end else begin
            ph_wr_q   <= acc && i_ahb.hwrite;
            ph_addr_q <= i_ahb.haddr[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (ph_wr_q && ph_addr_q == OFS_CTRL) begin
            ctrl_q <= i_ahb.hwdata & 32'h0000_1ff7;
        end
    end

    always_comb begin
        status = '0;
        status[ST_HV]                = hv_q;
        status[ST_READY]             = o_ready;
        status[ST_FAULT_FREE]        = !fault_q;
        status[ST_END]               = o_pulse_end;
        status[ST_ACCEPT]            = sel;
        status[ST_EMIT]              = emit_q;
        status[ST_WELD_HALT]         = halt_q;
        status[ST_BRANCH]            = branch_q;
        status[ST_DLV_LSB +: 4]      = dlv_q;
        status[ST_PRG_LSB +: 5]      = prg_q;
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rdata_q <= '0;
        end else if (acc && !i_ahb.hwrite) begin
            case (i_ahb.haddr[7:0])
                OFS_CTRL:   rdata_q <= ctrl_q;
                OFS_STATUS: rdata_q <= status;
                OFS_INPUTS: rdata_q <= {13'h0000, stop_err_s, stop_req_s, door_s, cin};
                default:    rdata_q <= '0;
            endcase
        end
    end

    assign o_hreadyout      = 1'b1;
    assign o_hresp          = 1'b0;
    assign o_hrdata         = rdata_q;
    assign o_high_voltage   = hv_q;
    assign o_ready          = hv_q && i_cap_charged;
    assign o_fault_free     = !fault_q;
    assign o_pulse_end      = end_cnt_q != '0;
    assign o_input_accepted = sel;
    assign o_fire           = fire_q;
    assign o_emitting       = emit_q;
    assign o_aim_light      = aim_q;
    assign o_cavity_open    = cav_q;
    assign o_delivery_sel   = dlv_q;
    assign o_program        = prg_q;
    assign o_weld_halt      = halt_q;
    assign o_branch_close   = branch_q;

    AST_HV_FOLLOWS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        sel |=> o_high_voltage == $past(cin.high_voltage_switch))
        else $error("High voltage does not follow its switch");
    AST_AIM_FOLLOWS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        sel && !cin.aim |=> !o_aim_light) else $error("Aiming light on without request");
    AST_BRANCH_CLOSE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_door_open) |-> ##3 o_branch_close) else $error("Branch shutter late on door open");
    AST_READY: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_ready |-> o_high_voltage && i_cap_charged) else $error("Ready without charge");
    AST_FAULT_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !o_fault_free && i_fault_cause |=> !o_fault_free) else $error("Fault cleared with cause present");
    AST_END_LEN: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_lamp_flashed |=> o_pulse_end && end_cnt_q == END_LEN) else $error("Pulse end not started");
    AST_FIRE_ONCE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_fire |=> !o_fire) else $error("Trigger fired twice");
    AST_IGNORE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !sel |=> !o_fire) else $error("Fire while external control off");
    AST_HALT: assert property (@(posedge i_clk) disable iff (!i_resetn)
        halt_rise || o_weld_halt |=> !o_emitting) else $error("Emission not ended by halt");
    AST_PROGRAM: assert property (@(posedge i_clk) disable iff (!i_resetn)
        sel ##1 sel |-> o_program == $past(cin.program_sel)) else $error("Program number wrong");
endmodule : ewci_top

// File: sim/ewci_seq_model.sv
/* Model of the external sequencer that closes the contact inputs.
   Assumes the bench gives base contact levels and one-cycle fire and stop requests. */
`timescale 1ns/1ps
module ewci_seq_model #(
    parameter int unsigned HOLD = 4,
    parameter int unsigned GAP  = 40,
    parameter int unsigned HALT = 10
) (
    input  wire logic                     i_clk,
    input  wire ewci_pkg::ewci_contacts_t i_base,
    input  wire logic                     i_fire,
    input  wire logic                     i_stop,
    output ewci_pkg::ewci_contacts_t      o_contacts,
    output logic                          o_busy
);
    import ewci_pkg::*;
    int unsigned cnt_q = 0;
    logic [1:0]  ph_q  = 2'h0;
    // Phases: idle, trigger, gap, halt
    always_ff @(posedge i_clk) begin
        if (ph_q == 2'h0 && (i_fire || i_stop)) begin
            ph_q  <= i_fire ? 2'h1 : 2'h3;
            cnt_q <= i_fire ? HOLD : HALT;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end else if (ph_q == 2'h1) begin
            ph_q  <= 2'h2;
            cnt_q <= GAP;
        end else begin
            ph_q  <= 2'h0;
            cnt_q <= 0;
        end
    end
    always_comb begin
        o_contacts         = i_base;
        o_contacts.trigger = (ph_q == 2'h1);
        o_contacts.halt    = (ph_q == 2'h1) || (ph_q == 2'h3);
        o_busy             = (ph_q != 2'h0);
    end
endmodule : ewci_seq_model

// File: sim/external_weld_control_inputs_test.sv
/* Bench of the weld control input block: bus, contacts, stop and door.
   Assumes the sequencer model beside it and a 10 MHz clock. */
`timescale 1ns/1ps
module external_weld_control_inputs_test;
    import ewci_pkg::*;
    localparam int unsigned END_LEN = 20;
    logic           i_clk    = 1'b0;
    logic           i_resetn = 1'b0;
    ewci_ahb_req_t  ahb_m    = '0;
    ewci_ahb_req_t  ahb;
    ewci_contacts_t base     = '0;
    ewci_contacts_t cts, c;
    logic           fire = 1'b0, stop = 1'b0, s_err = 1'b0, s_req = 1'b0, door = 1'b0;
    logic           f_ev = 1'b0, f_cause = 1'b0, cap = 1'b0, lamp = 1'b0, rd_ph = 1'b0;
    logic           busy, hrdy, fire_o, aim_o, cav_o;
    logic           hv_o, rdy_o, ff_o, pend_o, acc_o, emit_o, wh_o, bc_o, hresp;
    logic [3:0]     dlv_o;
    logic [4:0]     prg_o;
    logic [31:0]    hrdata, ctrl;
    logic [34:0]    expq[$];
    logic [34:0]    qe;
    logic           hv, aim, cav, acc, emit, pend, ff, wh, bc;
    logic [3:0]     dlv;
    logic [4:0]     prg;
    int             mismatches = 0, num_checks = 0, fires = 0, cycles = 0, seed = 76045;

    initial forever #50 i_clk = ~i_clk;
    always_comb begin
        ahb        = ahb_m;
        ahb.hready = hrdy;
    end

    ewci_seq_model #(.HOLD(4), .GAP(40), .HALT(10)) u_ewci_seq_model (
        .i_clk(i_clk), .i_base(base), .i_fire(fire), .i_stop(stop), .o_contacts(cts), .o_busy(busy));

    ewci_top #(.END_LEN(END_LEN)) u_ewci_top (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ahb(ahb), .o_hreadyout(hrdy), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_contacts(cts), .i_stop_error(s_err), .i_stop_request(s_req),
        .i_door_open(door), .i_fault_event(f_ev), .i_fault_cause(f_cause), .i_cap_charged(cap),
        .i_lamp_flashed(lamp), .o_high_voltage(hv_o), .o_ready(rdy_o), .o_fault_free(ff_o),
        .o_pulse_end(pend_o), .o_input_accepted(acc_o), .o_fire(fire_o), .o_emitting(emit_o),
        .o_aim_light(aim_o), .o_cavity_open(cav_o), .o_delivery_sel(dlv_o), .o_program(prg_o),
        .o_weld_halt(wh_o), .o_branch_close(bc_o));

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        ahb_m <= '{hsel: 1'b1, haddr: {24'h0, a}, htrans: HTRANS_NONSEQ, hwrite: wr,
                   hsize: 3'h2, hwdata: ahb_m.hwdata, hready: 1'b1};
        do @(posedge i_clk); while (hrdy !== 1'b1);
        ahb_m <= '{hsel: 1'b0, haddr: {24'h0, a}, htrans: 2'h0, hwrite: wr,
                   hsize: 3'h2, hwdata: d, hready: 1'b1};
        do @(posedge i_clk); while (hrdy !== 1'b1);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expq.push_back({a == OFS_STATUS, e});
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic st();
        rd(OFS_STATUS, {aim, cav, 15'h0, prg, dlv, bc, wh, emit, acc, pend, ff, hv & cap, hv});
    endtask : st

    task automatic settle();
        repeat (5) @(posedge i_clk);
    endtask : settle

    task automatic seq(input logic f);
        int n = 0;
        fire <= f;
        stop <= !f;
        @(posedge i_clk);
        fire <= 1'b0;
        stop <= 1'b0;
        @(posedge i_clk);
        while (busy === 1'b1 && n < 200) begin
            @(posedge i_clk);
            n++;
        end
        settle();
    endtask : seq

    // Result watcher: read data, fire pulses, timeout
    always @(posedge i_clk) begin
        cycles++;
        if (fire_o === 1'b1) fires++;
        if (rd_ph && hrdy === 1'b1) begin
            qe = expq.pop_front();
            chk("read", qe[33:0], {aim_o, cav_o, hrdata});
            if (qe[34]) chk("pins", qe[33:0], {aim_o, cav_o, 15'h0, prg_o, dlv_o, bc_o, wh_o, emit_o,
                                             acc_o, pend_o, ff_o, rdy_o, hv_o});
            chk("hresp", 34'h0, 34'(hresp));
        end
        rd_ph <= ahb.hsel && ahb.htrans == HTRANS_NONSEQ && !ahb.hwrite && hrdy;
        if (cycles == 30000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        {hv, aim, cav, acc, emit, pend, wh, bc, dlv, prg} = '0;
        ff = 1'b1;
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        st();
        rd(OFS_CTRL, {2'b0, CTRL_RESET});
        rd(8'h0c, 34'h0);
        ctrl = 32'($random(seed)) & 32'h0000_1ff7;
        cap <= 1'b1;
        wr_ctrl: bus(1'b1, OFS_CTRL, ctrl);
        settle();
        {hv, aim, cav, dlv, prg} = {ctrl[0], ctrl[1], ctrl[2], ctrl[7:4], ctrl[12:8]};
        st();
        rd(OFS_CTRL, {aim, cav, ctrl});
        for (int i = 0; i < 6; i++) begin
            c = ewci_contacts_t'($random(seed));
            c.external_control_select = (i != 0);
            c.fault_clear = 1'b0;
            c.high_voltage_switch = c.high_voltage_switch || (i == 5);
            base <= c;
            cap <= (i == 5) || ($random(seed) & 1);
            settle();
            if (i != 0) {hv, aim, cav, dlv, prg} = {c.high_voltage_switch, c.aim, c.cavity_shutter,
                                                     c.delivery_sel, c.program_sel};
            acc = (i != 0);
            st();
        end
        seq(1'b1);
        emit = 1'b1;
        st();
        seq(1'b0);
        emit = 1'b0;
        st();
        seq(1'b1);
        emit = 1'b1;
        st();
        lamp <= 1'b1;
        @(posedge i_clk);
        lamp <= 1'b0;
        pend = 1'b1;
        st();
        repeat (END_LEN) @(posedge i_clk);
        pend = 1'b0;
        st();
        f_cause <= 1'b1;
        f_ev <= 1'b1;
        @(posedge i_clk);
        f_ev <= 1'b0;
        {ff, emit} = 2'b00;
        bus(1'b1, OFS_CTRL, ctrl | 32'h2000);
        settle();
        st();
        f_cause <= 1'b0;
        bus(1'b1, OFS_CTRL, ctrl | 32'h2000);
        settle();
        ff = 1'b1;
        st();
        for (int k = 0; k < 3; k++) begin
            s_err <= (k == 0);
            s_req <= (k == 1);
            door <= (k == 2);
            settle();
            {wh, bc} = {k < 2, k == 2};
            st();
        end
        chk("fires", 34'd2, 34'(fires));
        print_verdict();
    end
endmodule : external_weld_control_inputs_test
